// ===== pkg/nvac_pkg.sv
// Package: register map, field positions and timing for the data memory block
package nvac_pkg;

    // Array size in bytes: one of 32, 64, 128, 256
    localparam int unsigned NVAC_ARRAY_BYTES = 256;
    localparam int unsigned NVAC_ADDR_BITS   = $clog2(NVAC_ARRAY_BYTES);

    // Register selects on the special function register port
    localparam logic [7:0] NVAC_ADDR_REG_OFS = 8'h00;
    localparam logic [7:0] NVAC_DATA_REG_OFS = 8'h01;
    localparam logic [7:0] NVAC_CTRL_REG_OFS = 8'h40;

    // Control register fields
    localparam int unsigned NVAC_WRITE_ENABLE_BIT_BIT  = 3;
    localparam int unsigned NVAC_WR_BIT    = 2;
    localparam int unsigned NVAC_READ_ENABLE_BIT_BIT  = 1;
    localparam int unsigned NVAC_RD_BIT    = 0;
    localparam logic [7:0]  NVAC_CTRL_RST  = 8'h00;
    localparam logic [7:0]  NVAC_CTRL_MASK = 8'h0F;

    // Banks that hold the control register and the data-side registers
    localparam logic [1:0] NVAC_CTRL_BANK = 2'h1;
    localparam logic [1:0] NVAC_DATA_BANK = 2'h0;

    // Timing: write cycle in microseconds, read latency in cycles
    localparam int unsigned NVAC_CLK_MHZ       = 125;
    localparam int unsigned NVAC_WRITE_US      = 2000;
    localparam int unsigned NVAC_WRITE_CYCLES  = NVAC_WRITE_US * NVAC_CLK_MHZ;
    localparam int unsigned NVAC_READ_CYCLES   = 4;
    // Internal write timer tick: one enable every this many clocks
    localparam int unsigned NVAC_TICK_DIV      = 125;

    typedef enum logic [1:0] {
        NVAC_IDLE  = 2'b00,
        NVAC_READ  = 2'b01,
        NVAC_WRITE = 2'b10
    } nvac_state_t;

    // Special function register access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvac_sfr_req_t;

endpackage

// ===== verilog/nvac_top.sv
// Top: byte-wide nonvolatile data memory with address, data, control regs
//
// Notes on behaviour
// - Byte array, 32 to 256 bytes, zero based.
// - Not memory mapped; address, data, control registers.
// - Address register width follows size; upper bits zero.
// - Control bits 3..0 enables/starts, reset zero.
// - Write enable clear blocks all array writes.
// - Write start begins write; hardware clears at end.
// - Write start without prior enable is ignored.
// - Read enable clear blocks all array reads.
// - Read start begins read; hardware clears at end.
// - Read start without prior enable is ignored.
// - Completed read loads data register, held there.
// - Internal timer times write; start stays set.
// - Write end sets done flag and shared request.
`timescale 1ns/1ps

module nvac_top
    import nvac_pkg::*;
#(
    parameter int unsigned WRITE_TICKS = NVAC_WRITE_US * 1,
    parameter int unsigned TICK_DIV    = NVAC_TICK_DIV,
    parameter int unsigned READ_CYCLES = NVAC_READ_CYCLES
) (
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire nvac_pkg::nvac_sfr_req_t sfr_req,
    output logic [7:0]                  sfr_rdata,
    output logic                        nv_done_flag,
    output logic                        nv_done_irq_req,
    input  wire logic                   nv_done_clear,
    output logic                        busy
);
    import nvac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    logic                      addr_sel;
    logic                      data_sel;
    logic                      ctrl_sel;
    logic [NVAC_ADDR_BITS-1:0] nv_address_q;
    logic [7:0]                nv_data_q;
    logic [3:0]                nv_control_q;
    logic [7:0]                mem_q [NVAC_ARRAY_BYTES];
    nvac_state_t               state_q;
    logic [31:0]               cnt_q;
    logic [7:0]                div_q;
    logic                      tick;
    logic                      wr_start;
    logic                      rd_start;
    logic                      cycle_end;
    logic [7:0]                ctrl_rd;
    logic [7:0]                addr_rd;

    // Data-side registers in bank 0, control only in bank 1
    assign addr_sel = sfr_req.bank == NVAC_DATA_BANK &&
                      sfr_req.addr == NVAC_ADDR_REG_OFS;
    assign data_sel = sfr_req.bank == NVAC_DATA_BANK &&
                      sfr_req.addr == NVAC_DATA_REG_OFS;
    assign ctrl_sel = sfr_req.bank == NVAC_CTRL_BANK &&
                      sfr_req.addr == NVAC_CTRL_REG_OFS;

    // Start only counts if the enable was already set before this write
    assign wr_start = sfr_req.wr && ctrl_sel && state_q == NVAC_IDLE &&
                      sfr_req.wdata[NVAC_WR_BIT] &&
                      nv_control_q[NVAC_WRITE_ENABLE_BIT_BIT];
    assign rd_start = sfr_req.wr && ctrl_sel && state_q == NVAC_IDLE &&
                      !wr_start && sfr_req.wdata[NVAC_RD_BIT] &&
                      nv_control_q[NVAC_READ_ENABLE_BIT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Write timer tick divider; stands in for the free-running write timer

    always_ff @(posedge sys_clk) begin
        if (srst || div_q == 8'(TICK_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign tick = div_q == 8'(TICK_DIV - 1);

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer

    assign cycle_end = (state_q == NVAC_READ && cnt_q == 32'(READ_CYCLES - 1))
                    || (state_q == NVAC_WRITE && tick &&
                        cnt_q == 32'(WRITE_TICKS - 1));

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= NVAC_IDLE;
            cnt_q   <= 32'h0;
        end else begin
            case (state_q)
                NVAC_IDLE: begin
                    cnt_q <= 32'h0;
                    if (wr_start) begin
                        state_q <= NVAC_WRITE;
                    end else if (rd_start) begin
                        state_q <= NVAC_READ;
                    end
                end
                NVAC_READ: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (cycle_end) begin
                        state_q <= NVAC_IDLE;
                    end
                end
                NVAC_WRITE: begin
                    if (tick) begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                    if (cycle_end) begin
                        state_q <= NVAC_IDLE;
                    end
                end
                default: begin
                    state_q <= NVAC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            nv_control_q <= NVAC_CTRL_RST[3:0];
        end else begin
            if (sfr_req.wr && ctrl_sel) begin
                nv_control_q[NVAC_WRITE_ENABLE_BIT_BIT] <= sfr_req.wdata[NVAC_WRITE_ENABLE_BIT_BIT];
                nv_control_q[NVAC_READ_ENABLE_BIT_BIT] <= sfr_req.wdata[NVAC_READ_ENABLE_BIT_BIT];
            end
            // Start bits: set only when accepted, held while busy
            if (wr_start) begin
                nv_control_q[NVAC_WR_BIT] <= 1'b1;
            end else if (state_q == NVAC_WRITE && cycle_end) begin
                nv_control_q[NVAC_WR_BIT] <= 1'b0;
            end
            if (rd_start) begin
                nv_control_q[NVAC_RD_BIT] <= 1'b1;
            end else if (state_q == NVAC_READ && cycle_end) begin
                nv_control_q[NVAC_RD_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address, data and array; address and data have no reset by design

    always_ff @(posedge sys_clk) begin
        if (sfr_req.wr && addr_sel) begin
            nv_address_q <= sfr_req.wdata[NVAC_ADDR_BITS-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (state_q == NVAC_READ && cycle_end &&
            nv_control_q[NVAC_READ_ENABLE_BIT_BIT]) begin
            nv_data_q <= mem_q[nv_address_q];
        end else if (sfr_req.wr && data_sel) begin
            nv_data_q <= sfr_req.wdata;
        end
    end

    // Clearing write enable mid-cycle aborts the commit
    always_ff @(posedge sys_clk) begin
        if (state_q == NVAC_WRITE && cycle_end &&
            nv_control_q[NVAC_WRITE_ENABLE_BIT_BIT]) begin
            mem_q[nv_address_q] <= nv_data_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back and status outputs

    assign addr_rd = 8'(nv_address_q);
    assign ctrl_rd = {4'h0, nv_control_q} & NVAC_CTRL_MASK;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd && addr_sel) begin
            sfr_rdata <= addr_rd;
        end else if (sfr_req.rd && data_sel) begin
            sfr_rdata <= nv_data_q;
        end else if (sfr_req.rd && ctrl_sel) begin
            sfr_rdata <= ctrl_rd;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            nv_done_flag    <= 1'b0;
            nv_done_irq_req <= 1'b0;
        end else begin
            nv_done_irq_req <= state_q == NVAC_WRITE && cycle_end;
            if (state_q == NVAC_WRITE && cycle_end) begin
                nv_done_flag <= 1'b1;
            end else if (nv_done_clear) begin
                nv_done_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_q != NVAC_IDLE && !cycle_end) ||
                    wr_start || rd_start;
        end
    end

endmodule

// ===== tb/nvac_top_asserts.sv
// Checker: port assertions for the data memory controller
`timescale 1ns/1ps
module nvac_top_asserts
    import nvac_pkg::*;
#(
    parameter int unsigned WRITE_TICKS = NVAC_WRITE_US,
    parameter int unsigned TICK_DIV    = NVAC_TICK_DIV,
    parameter int unsigned READ_CYCLES = NVAC_READ_CYCLES
) (
    input wire logic                    sys_clk,
    input wire logic                    srst,
    input wire nvac_pkg::nvac_sfr_req_t sfr_req,
    input wire logic [7:0]              sfr_rdata,
    input wire logic                    nv_done_flag,
    input wire logic                    nv_done_irq_req,
    input wire logic                    nv_done_clear,
    input wire logic                    busy
);
    // Slack covers the tick phase at start
    localparam int LIM = WRITE_TICKS * TICK_DIV + READ_CYCLES + 8;
    logic write_enable_bit_q;
    logic read_enable_bit_q;
    // Counter, not a delay range: full-size write time is far too long
    logic [31:0] run_q;
    wire  ctl_wr = sfr_req.wr && sfr_req.bank == NVAC_CTRL_BANK
                   && sfr_req.addr == NVAC_CTRL_REG_OFS;
    wire  ctl_rd = sfr_req.rd && sfr_req.bank == NVAC_CTRL_BANK
                   && sfr_req.addr == NVAC_CTRL_REG_OFS;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the enables: only software writes them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            write_enable_bit_q <= 1'b0;
            read_enable_bit_q <= 1'b0;
        end else if (ctl_wr) begin
            write_enable_bit_q <= sfr_req.wdata[NVAC_WRITE_ENABLE_BIT_BIT];
            read_enable_bit_q <= sfr_req.wdata[NVAC_READ_ENABLE_BIT_BIT];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst || !busy) begin
            run_q <= 32'h0;
        end else begin
            run_q <= run_q + 32'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_wr_needs_en:
        assert property (ctl_wr && sfr_req.wdata[NVAC_WR_BIT] && !write_enable_bit_q
            && !busy |=> !busy [*2]) else $error("write ran unenabled");
    a_rd_needs_en:
        assert property (ctl_wr && sfr_req.wdata[NVAC_RD_BIT] && !read_enable_bit_q
            && !busy |=> !busy [*2]) else $error("read ran unenabled");
    a_start_runs:
        assert property (ctl_wr && !busy && (sfr_req.wdata[NVAC_WR_BIT]
            && write_enable_bit_q || sfr_req.wdata[NVAC_RD_BIT] && read_enable_bit_q)
            |-> ##[1:2] busy) else $error("start did not run");
    a_cycle_ends:
        assert property (run_q < 32'(LIM))
            else $error("cycle never ended");
    a_flag_irq:
        assert property ($rose(nv_done_flag) |-> nv_done_irq_req)
            else $error("done flag without request");
    a_flag_cause:
        assert property ($rose(nv_done_flag) |-> $past(busy) || $past(busy, 2))
            else $error("done flag without cycle");
    a_irq_pulse:
        assert property (nv_done_irq_req |=> !nv_done_irq_req)
            else $error("request longer than one cycle");
    a_irq_flag:
        assert property (nv_done_irq_req |-> ##[0:1] nv_done_flag)
            else $error("request without done flag");
    a_flag_holds:
        assert property ($fell(nv_done_flag) |-> $past(nv_done_clear)
            || $past(srst)) else $error("done flag lost");
    a_rdata_idle:
        assert property (!$past(sfr_req.rd) |-> sfr_rdata == 8'h00)
            else $error("read data not zero");
    a_ctrl_upper:
        assert property ($past(ctl_rd) |-> sfr_rdata[7:4] == 4'h0)
            else $error("control upper bits set");
    c_write_done: cover property ($rose(nv_done_flag));
    c_read_run: cover property (ctl_wr && sfr_req.wdata[0] && read_enable_bit_q);
    c_busy_end: cover property ($fell(busy) && !nv_done_flag);
endmodule

bind nvac_top nvac_top_asserts #(.WRITE_TICKS(WRITE_TICKS),
    .TICK_DIV(TICK_DIV), .READ_CYCLES(READ_CYCLES)) i_nvac_top_asserts (
    .sys_clk(sys_clk), .srst(srst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .nv_done_flag(nv_done_flag),
    .nv_done_irq_req(nv_done_irq_req), .nv_done_clear(nv_done_clear),
    .busy(busy));

// ===== tb/nvac_top_tb.sv
// Testbench: random and corner accesses to the data memory controller
`timescale 1ns/1ps
module nvac_top_tb;
    import nvac_pkg::*;
    logic          sys_clk = 1'b0;
    logic          srst = 1'b1;
    nvac_sfr_req_t sfr_req = '0;
    logic [7:0]    sfr_rdata;
    logic          nv_done_flag;
    logic          nv_done_irq_req;
    logic          nv_done_clear = 1'b0;
    logic          busy;
    int            err_count = 0;
    int            comparisons = 0;
    int            irq_count = 0;
    logic [7:0]    mem [256];
    logic [7:0]    a;
    logic [7:0]    v;
    logic [7:0]    bad [4] = '{8'h04, 8'h01, 8'h0C, 8'h03};

    // Short write cycle keeps the run brief
    nvac_top #(.WRITE_TICKS(3), .TICK_DIV(2), .READ_CYCLES(4)) i_nvac_top (
        .sys_clk(sys_clk), .srst(srst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .nv_done_flag(nv_done_flag),
        .nv_done_irq_req(nv_done_irq_req), .nv_done_clear(nv_done_clear),
        .busy(busy));
    always #4 sys_clk = ~sys_clk;
    // Request pulses counted at the falling edge, where they are settled
    always @(negedge sys_clk) begin
        if (nv_done_irq_req === 1'b1) begin
            irq_count++;
        end
    end
    // Address read-back keeps only the bits the array size implements
    function automatic logic [7:0] exp_addr(logic [7:0] x);
        return x & 8'(NVAC_ARRAY_BYTES - 1);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One access; read data is registered, so taken after the next edge
    task automatic sfr(logic w, logic [1:0] bk, logic [7:0] ad,
                       logic [7:0] wd);
        @(posedge sys_clk);
        #1 sfr_req = '{wr: w, rd: !w, bank: bk, addr: ad, wdata: wd};
        @(posedge sys_clk);
        #1 sfr_req.wr = 1'b0;
        sfr_req.rd = 1'b0;
        v = sfr_rdata;
    endtask
    task automatic ctl(logic [7:0] x);
        sfr(1'b1, NVAC_CTRL_BANK, NVAC_CTRL_REG_OFS, x);
    endtask
    task automatic poll(int idx);
        for (int i = 0; i < 40; i++) begin
            sfr(1'b0, NVAC_CTRL_BANK, NVAC_CTRL_REG_OFS, 8'h00);
            if (v[idx] === 1'b0) return;
        end
        check("start bit", 8'h00, 8'h01);
        print_verdict();
    endtask
    task automatic write_byte(logic [7:0] ad, logic [7:0] dt, logic drop);
        ctl(8'h08);
        sfr(1'b1, NVAC_DATA_BANK, NVAC_ADDR_REG_OFS, ad);
        sfr(1'b1, NVAC_DATA_BANK, NVAC_DATA_REG_OFS, dt);
        ctl(8'h0C);
        if (drop) ctl(8'h04);
        poll(NVAC_WR_BIT);
    endtask
    task automatic read_byte(logic [7:0] ad, logic drop);
        ctl(8'h02);
        sfr(1'b1, NVAC_DATA_BANK, NVAC_ADDR_REG_OFS, ad);
        ctl(8'h03);
        if (drop) ctl(8'h01);
        poll(NVAC_RD_BIT);
        sfr(1'b0, NVAC_DATA_BANK, NVAC_DATA_REG_OFS, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(6));
        repeat (4) @(posedge sys_clk);
        #1 srst = 1'b0;
        sfr(1'b0, NVAC_CTRL_BANK, NVAC_CTRL_REG_OFS, 8'h00);
        check("control reset", NVAC_CTRL_RST, v);
        sfr(1'b0, NVAC_DATA_BANK, 8'h22, 8'h00);
        check("unmapped", 8'h00, v);
        foreach (bad[k]) begin
            ctl(bad[k]);
            sfr(1'b0, NVAC_CTRL_BANK, NVAC_CTRL_REG_OFS, 8'h00);
            check("refused start", 8'h00, v & 8'h05);
        end
        for (int n = 0; n < 8; n++) begin
            a = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($urandom);
            mem[a] = 8'($urandom);
            write_byte(a, mem[a], 1'b0);
            check("done flag", 8'h01, {7'h00, nv_done_flag});
            check("busy idle", 8'h00, {7'h00, busy});
            @(posedge sys_clk);
            #1 nv_done_clear = 1'b1;
            @(posedge sys_clk);
            #1 nv_done_clear = 1'b0;
            check("flag clear", 8'h00, {7'h00, nv_done_flag});
            read_byte(a, 1'b0);
            check("read data", mem[a], v);
            sfr(1'b0, NVAC_DATA_BANK, NVAC_ADDR_REG_OFS, 8'h00);
            check("address reg", exp_addr(a), v);
        end
        check("irq pulses", 8'h08, 8'(irq_count));
        // Enable dropped mid-cycle must leave the byte untouched
        write_byte(8'h10, 8'h3C, 1'b0);
        write_byte(8'h10, 8'hC3, 1'b1);
        read_byte(8'h10, 1'b0);
        check("blocked write", 8'h3C, v);
        sfr(1'b1, NVAC_DATA_BANK, NVAC_DATA_REG_OFS, 8'h77);
        read_byte(8'h10, 1'b1);
        check("blocked read", 8'h77, v);
        print_verdict();
    end
endmodule
